// [include/frame_bus_defs.svh]
`ifndef FRAME_BUS_DEFS_SVH
`define FRAME_BUS_DEFS_SVH

// ==========================================
// frame positions (bit numbers on the link)
`define POS_FIRST 7'd0
`define POS_LAST 7'd63
`define POS_END 7'd64
`define POS_RSV0_LO 7'd12
`define POS_RSV0_HI 7'd16
`define POS_ADDR_LO 7'd17
`define POS_ADDR_HI 7'd20
`define POS_WFLAG 7'd21
`define POS_RSV1_LO 7'd22
`define POS_RSV1_HI 7'd29
`define POS_RSV2_LO 7'd46
`define POS_RSV2_HI 7'd47
`define POS_DATA 7'd48

// ==========================================
// receive word layout (position p sits at index 63-p)
`define RX_AUD_MSB 63
`define RX_ADDR_MSB 46
`define RX_WFLAG 42
`define RX_AUD_VALID 33
`define RX_TEL_VALID 32
`define RX_TEL_MSB 31
`define RX_DATA_MSB 15

// ==========================================
// field widths
`define AUD_W 12
`define TEL_W 14
`define ADDR_W 4
`define DATA_W 16
`define NUM_CREG 16

// ==========================================
// control register 1 holds the zero-fill option
`define ZFILL_REG 4'h1
`define ZFILL_BIT 15

// ==========================================
// apb byte offsets and fields
`define A_AUD_OUT 12'h000
`define A_TEL_OUT 12'h004
`define A_AUD_IN 12'h008
`define A_TEL_IN 12'h00c
`define A_STATUS 12'h010
`define A_CREG_PAGE 6'h01
`define AUD_OUT_VALID 12
`define TEL_OUT_VALID 14
`define ST_AUD_NEW 0
`define ST_TEL_NEW 1

`endif

// [include/frame_bus_pkg.sv]
package frame_bus_pkg;

   // link pins, raw or as seen after synchronising
   typedef struct packed {
      logic bus_clock;
      logic frame_sync;
      logic serial_in;
   } link_in_s;

   // one-cycle strobes on bus_clock edges
   typedef struct packed {
      logic rise;
      logic fall;
   } link_edge_s;

   typedef logic [6:0] pos_t;
   typedef logic [15:0] creg_t;

endpackage

// [logic/bit_counter.sv]
`timescale 1ns/100ps
`include "frame_bus_defs.svh"
module bit_counter
   import frame_bus_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // frame timing
   input wire logic rise,
   input wire logic sync_seen,
   // position in frame
   output pos_t pos,
   output pos_t pos_next
);
   pos_t pos_reg;

   // parks at 64 so the word field stays idle until the next sync
   assign pos_next = !rise ? pos_reg :
                     sync_seen ? `POS_FIRST :
                     (pos_reg < `POS_END) ? pos_reg + 7'd1 : pos_reg; // [R22]

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pos_reg <= `POS_END;
      end else begin
         pos_reg <= pos_next;
      end
   end

   assign pos = pos_reg;
endmodule

// [logic/frame_port.sv]
`timescale 1ns/100ps
`include "frame_bus_defs.svh"

//Behaviour
// R1 - frames are at least 64 bits; only positions 0 to 63 are used
// R2 - serial output released from position 64 to frame end by default
// R3 - with zero-fill set in control register 1, drive low from 64
// R4 - sample input on falling bus clock, launch output on rising edge
// R5 - sync pulse just before a frame marks the start of position 0
// R6 - controller keeps bus clock running while any function is on
// R7 - controller stops bus clock only when idle, at a frame boundary
// R8 - positions 0 to 11 carry the 12-bit audio sample, msb first
// R9 - positions 12-16, 22-29, 46-47 ignored inbound, zero outbound
// R10 - positions 17 to 20 carry the 4-bit register address, msb first
// R11 - outgoing address field echoes the received address, delayed
// R12 - position 21 is the write flag; outgoing position 21 always low
// R13 - positions 30 and 31 are audio and telecom valid flags
// R14 - positions 32 to 45 carry the 14-bit telecom sample, msb first
// R15 - positions 48 to 63 carry 16-bit register data, msb first
// R16 - a read returns the addressed register in the same frame
// R17 - a write loads the addressed register at position 64
// R18 - a write frame returns the value from before the update
// R19 - frames with write flag low never change a register
// R20 - returned register data is captured just before the frame
// R21 - incoming samples are kept only when their valid flag is set
// R22 - bit counter restarts on sync and idles after position 63
module frame_port
   import frame_bus_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // frame bus pins
   input wire logic bus_clock,
   input wire logic frame_sync,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe_n
);
   // ==========================================
   // link front end
   link_in_s pins;
   link_in_s lvl;
   link_edge_s ev;
   pos_t pos;
   pos_t pos_next;
   logic sync_seen_reg;

   assign pins = '{bus_clock: bus_clock, frame_sync: frame_sync,
                   serial_in: serial_in};

   pin_sync u_sync (
      .mclk(mclk),
      .rstn(rstn),
      .pins(pins),
      .lvl(lvl),
      .ev(ev)
   );

   bit_counter u_count (
      .mclk(mclk),
      .rstn(rstn),
      .rise(ev.rise),
      .sync_seen(sync_seen_reg),
      .pos(pos),
      .pos_next(pos_next)
   );

   function automatic logic [5:0] bit_index(input pos_t p);
      bit_index = 6'(`POS_LAST - p);
   endfunction

   // ==========================================
   // receive side
   logic [63:0] rx_word_reg;
   logic frame_start;
   logic frame_end;
   logic [`ADDR_W-1:0] rx_addr;
   logic rx_wflag;
   creg_t rx_data;
   logic in_word;

   assign in_word = pos < `POS_END;
   assign frame_start = ev.fall & lvl.frame_sync;
   // a sync landing in bit 63 must not swallow the word's update
   assign frame_end = ev.rise & (pos == `POS_LAST);
   assign rx_addr = rx_word_reg[`RX_ADDR_MSB -: `ADDR_W];
   assign rx_wflag = rx_word_reg[`RX_WFLAG];
   assign rx_data = rx_word_reg[`RX_DATA_MSB -: `DATA_W];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rx_word_reg <= '0;
         sync_seen_reg <= 1'b0;
      end else if (ev.fall) begin
         sync_seen_reg <= lvl.frame_sync; // [R5]
         if (in_word) begin
            rx_word_reg[bit_index(pos)] <= lvl.serial_in; // [R4] [R1]
         end
      end
   end

   // ==========================================
   // control registers and pre-frame snapshot
   creg_t creg [`NUM_CREG];
   creg_t snap [`NUM_CREG];
   logic zero_fill;

   assign zero_fill = creg[`ZFILL_REG][`ZFILL_BIT];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `NUM_CREG; i++) begin
            creg[i] <= '0;
         end
      end else if (frame_end && rx_wflag) begin
         creg[rx_addr] <= rx_data; // [R17] [R19]
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `NUM_CREG; i++) begin
            snap[i] <= '0;
         end
      end else if (frame_start) begin
         snap <= creg; // [R20]
      end
   end

   // ==========================================
   // samples between software and the link
   logic [`AUD_W:0] aud_out_reg;
   logic [`TEL_W:0] tel_out_reg;
   logic [`AUD_W:0] aud_tx_reg;
   logic [`TEL_W:0] tel_tx_reg;
   logic [`AUD_W-1:0] aud_in_reg;
   logic [`TEL_W-1:0] tel_in_reg;
   logic aud_new_reg;
   logic tel_new_reg;
   logic aud_take;
   logic tel_take;

   assign aud_take = frame_end & rx_word_reg[`RX_AUD_VALID];
   assign tel_take = frame_end & rx_word_reg[`RX_TEL_VALID];

   // latched before the frame so a mid-frame apb write cannot tear it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         aud_tx_reg <= '0;
         tel_tx_reg <= '0;
      end else if (frame_start) begin
         aud_tx_reg <= aud_out_reg;
         tel_tx_reg <= tel_out_reg;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         aud_in_reg <= '0;
         tel_in_reg <= '0;
      end else begin
         if (aud_take) begin
            aud_in_reg <= rx_word_reg[`RX_AUD_MSB -: `AUD_W]; // [R21] [R8]
         end
         if (tel_take) begin
            tel_in_reg <= rx_word_reg[`RX_TEL_MSB -: `TEL_W]; // [R21] [R14]
         end
      end
   end

   // ==========================================
   // transmit side
   logic [63:0] tx_vec;
   creg_t rd_data;
   logic echo_pos;

   assign rd_data = snap[rx_addr]; // [R16] [R18]
   assign echo_pos = (pos >= `POS_ADDR_LO) & (pos <= `POS_ADDR_HI);
   assign tx_vec = {aud_tx_reg[`AUD_W-1:0], 5'h00, 4'h0, // [R9]
                    1'b0, 8'h00, aud_tx_reg[`AUD_OUT_VALID], // [R12] [R13]
                    tel_tx_reg[`TEL_OUT_VALID], tel_tx_reg[`TEL_W-1:0], 2'h0,
                    rd_data}; // [R15]

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         serial_out <= 1'b0;
         serial_out_oe_n <= 1'b1;
      end else if (ev.rise) begin
         if (pos_next < `POS_END) begin
            serial_out <= tx_vec[bit_index(pos_next)]; // [R4]
            serial_out_oe_n <= 1'b0;
         end else begin
            serial_out <= 1'b0;
            serial_out_oe_n <= ~zero_fill; // [R2] [R3]
         end
      end else if (ev.fall && echo_pos) begin
         serial_out <= lvl.serial_in; // [R11] [R10]
      end
   end

   // ==========================================
   // apb slave: zero-wait, answer in first access cycle
   logic setup;
   logic access;
   logic wr;
   logic clr;
   logic creg_hit;
   logic hit;
   logic [31:0] rd_mux;

   assign setup = psel & ~penable;
   assign access = psel & penable & pready;
   assign wr = access & pwrite;
   assign clr = wr & (paddr == `A_STATUS);
   assign creg_hit = paddr[11:6] == `A_CREG_PAGE;
   assign hit = creg_hit | (paddr == `A_AUD_OUT) | (paddr == `A_TEL_OUT) |
                (paddr == `A_AUD_IN) | (paddr == `A_TEL_IN) |
                (paddr == `A_STATUS);
   assign rd_mux =
      creg_hit ? {16'h0000, creg[paddr[5:2]]} :
      (paddr == `A_AUD_OUT) ? {19'h00000, aud_out_reg} :
      (paddr == `A_TEL_OUT) ? {17'h00000, tel_out_reg} :
      (paddr == `A_AUD_IN) ? {20'h00000, aud_in_reg} :
      (paddr == `A_TEL_IN) ? {18'h00000, tel_in_reg} :
      (paddr == `A_STATUS) ? {17'h00000, pos, 6'h00, tel_new_reg,
                              aud_new_reg} : 32'h00000000;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata <= rd_mux;
            pslverr <= ~hit;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         aud_out_reg <= '0;
         tel_out_reg <= '0;
      end else if (wr) begin
         if (paddr == `A_AUD_OUT) begin
            aud_out_reg <= pwdata[`AUD_W:0];
         end
         if (paddr == `A_TEL_OUT) begin
            tel_out_reg <= pwdata[`TEL_W:0];
         end
      end
   end

   // a sample arriving with the clear still counts
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         aud_new_reg <= 1'b0;
         tel_new_reg <= 1'b0;
      end else begin
         aud_new_reg <= aud_take | (aud_new_reg &
                        ~(clr & pwdata[`ST_AUD_NEW]));
         tel_new_reg <= tel_take | (tel_new_reg &
                        ~(clr & pwdata[`ST_TEL_NEW]));
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   creg_t creg_sel;
   assign creg_sel = creg[rx_addr];
   sequence s_word_done;
      ev.rise && pos == `POS_LAST;
   endsequence

   sequence s_launch(pos_t p);
      ev.rise && pos_next == p;
   endsequence

   chk_release_oe: assert property ( // [R2]
      (s_launch(`POS_END) and !zero_fill) |=> serial_out_oe_n)
      else $error("serial output not released after word");

   chk_zero_fill: assert property ( // [R3]
      (s_launch(`POS_END) and zero_fill) |=> !serial_out_oe_n && !serial_out)
      else $error("zero fill not driven low");

   chk_reserved_low: assert property ( // [R9]
      ev.rise && ((pos_next >= `POS_RSV0_LO && pos_next <= `POS_RSV0_HI) ||
      (pos_next >= `POS_RSV1_LO && pos_next <= `POS_RSV1_HI) ||
      (pos_next >= `POS_RSV2_LO && pos_next <= `POS_RSV2_HI))
      |=> !serial_out && !serial_out_oe_n)
      else $error("reserved output bit not zero");

   chk_wflag_low: assert property ( // [R12]
      s_launch(`POS_WFLAG) |=> !serial_out)
      else $error("outgoing write flag not low");

   chk_frame_restart: assert property ( // [R5]
      ev.rise && sync_seen_reg |=> pos == `POS_FIRST)
      else $error("counter did not restart on sync");

   chk_write_load: assert property ( // [R17]
      s_word_done and rx_wflag |=> creg_sel == $past(rx_data))
      else $error("write data not loaded at position 64");

   chk_read_no_write: assert property ( // [R19]
      s_word_done and !rx_wflag |=> $stable(creg_sel))
      else $error("register changed in read frame");

   chk_old_data: assert property ( // [R18]
      s_launch(`POS_DATA) |=> serial_out == $past(rd_data[15]))
      else $error("data msb not from pre-frame snapshot");

   chk_discard: assert property ( // [R21]
      s_word_done and !rx_word_reg[`RX_AUD_VALID] |=> $stable(aud_in_reg))
      else $error("audio kept without valid flag");

   chk_addr_echo: assert property ( // [R11]
      ev.fall && echo_pos |=> serial_out == $past(lvl.serial_in))
      else $error("address echo mismatch");

   chk_idle_count: assert property ( // [R22]
      pos == `POS_END && !(ev.rise && sync_seen_reg) |=> pos == `POS_END)
      else $error("counter left idle without sync");
endmodule

// [logic/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync
   import frame_bus_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // raw link pins
   input link_in_s pins,
   // synchronised levels and edges
   output link_in_s lvl,
   output link_edge_s ev
);
   link_in_s meta_reg;
   link_in_s lvl_reg;
   logic clk_d_reg;

   // first stage feeds the second only
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '0;
         lvl_reg <= '0;
         clk_d_reg <= 1'b0;
      end else begin
         meta_reg <= pins;
         lvl_reg <= meta_reg;
         clk_d_reg <= lvl_reg.bus_clock;
      end
   end

   assign lvl = lvl_reg;
   assign ev.rise = lvl_reg.bus_clock & ~clk_d_reg;
   assign ev.fall = ~lvl_reg.bus_clock & clk_d_reg;
endmodule

// [tb/codec_frame_serial_port_bench.sv]
`timescale 1ns/100ps
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin \
n_mismatch++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
end end
module codec_frame_serial_port_bench;
   logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, serial_out, serial_out_oe_n;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q, r, r2, t, seed = 32'd57135;
   logic [31:0] aud_in = '0, tel_in = '0, st = '0;
   logic bus_clock, frame_sync, serial_in, err, zf, wf;
   logic [63:0] w, e, g;
   logic [71:0] qo, qe;
   logic [15:0] creg [16];
   logic [15:0] d16;
   logic [3:0] ad;
   int n_mismatch = 0, total_checks = 0, nb;

   always #12.5 mclk = ~mclk;

   frame_port dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus_clock(bus_clock),
      .frame_sync(frame_sync), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));

   frame_master host (.mclk(mclk), .bus_clock(bus_clock),
      .frame_sync(frame_sync), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));

   // ==========================================
   // helpers
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         complete_run();
      end else begin
         q = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task rd_chk(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, '0);
      `CHECK(q, x)
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      for (int k = 0; k < 16; k++) begin
         creg[k] = '0;
         rd_chk(12'h040 + 12'(4 * k), 32'h0);
      end
      rd_chk(12'h010, 32'h4000);
      rd_chk(12'h020, 32'h0);
      `CHECK(err, 1'b1)
      $display("reset test done");
      for (int i = 0; i < 10; i++) begin
         r = rnd();
         r2 = rnd();
         t = rnd();
         // register 1 only touched on purpose, so the tail stays known
         ad = (r[3:0] == 4'h1) ? 4'h2 : r[3:0];
         wf = r[4];
         d16 = r2[29:14];
         if (i == 2 || i == 6) begin
            ad = 4'h1;
            wf = 1'b1;
            d16[15] = (i == 2);
         end
         nb = i[0] ? 72 : 64;
         apb(1'b1, 12'h000, {19'h0, t[12:0]});
         apb(1'b1, 12'h004, {17'h0, t[30:16]});
         w = {r[31:20], r[19:15], ad, wf, r[14:7], r[6], r[5], r2[13:0],
            r2[31:30], d16};
         e = {t[11:0], 5'h0, ad, 1'b0, 8'h0, t[12], t[30], t[29:16], 2'h0,
            creg[ad]};
         zf = creg[1][15];
         host.frame(w, nb, qo, qe);
         for (int p = 0; p < 64; p++) g[63 - p] = qo[p];
         `CHECK(g, e)
         `CHECK(qe[63:0], 64'h0)
         if (nb == 72) begin
            `CHECK(qe[71:64], zf ? 8'h00 : 8'hff)
            if (zf) `CHECK(qo[71:64], 8'h00)
         end
         if (wf) creg[ad] = d16;
         if (r[6]) aud_in = {20'h0, r[31:20]};
         if (r[5]) tel_in = {18'h0, r2[13:0]};
         st = st | {30'h0, r[5], r[6]};
         rd_chk(12'h008, aud_in);
         rd_chk(12'h00c, tel_in);
         rd_chk(12'h010, 32'h4000 | st);
         apb(1'b1, 12'h010, {30'h0, t[15:14]});
         st = st & ~{30'h0, t[15:14]};
         apb(1'b1, 12'h040 + {6'h0, ad, 2'h0}, r2);
         rd_chk(12'h040 + {6'h0, ad, 2'h0}, {16'h0, creg[ad]});
         $display("frame %0d done", i);
      end
      rd_chk(12'h010, 32'h4000 | st);
      complete_run();
   end

   // ==========================================
   // hang guard
   initial begin
      #2500000;
      n_mismatch++;
      complete_run();
   end
endmodule

// [tb/frame_master.sv]
`timescale 1ns/100ps
module frame_master (
   // system clock, paces the link only
   input wire logic mclk,
   // frame bus
   output logic bus_clock,
   output logic frame_sync,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe_n
);
   logic busy;

   initial begin
      busy = 1'b0;
      bus_clock = 1'b0;
      frame_sync = 1'b0;
      serial_in = 1'b0;
   end

   // ==========================================
   // idle data line
   // no pull on this line: toggle so stale bits never pass as data
   always @(posedge mclk) begin
      if (!busy) serial_in <= ~serial_in;
   end

   // ==========================================
   // one frame, w holds positions 0..63 msb first
   task frame(input logic [63:0] w, input int nbits,
      output logic [71:0] q_out, output logic [71:0] q_oen);
      q_out = '0;
      q_oen = '1;
      busy = 1'b1;
      // clock runs through the frame, stands low only after it
      for (int p = -1; p <= nbits; p++) begin
         @(posedge mclk);
         bus_clock <= 1'b1;
         frame_sync <= (p == -1);
         if (p >= 0 && p < 64) serial_in <= w[63 - p];
         else if (p >= 64 && p < nbits) serial_in <= ~w[127 - p];
         // sampled after the echo settles, before the next launch
         repeat (2) @(posedge mclk);
         if (p >= 1) begin
            q_out[p - 1] = serial_out;
            q_oen[p - 1] = serial_out_oe_n;
         end
         repeat (2) @(posedge mclk);
         bus_clock <= 1'b0;
         repeat (3) @(posedge mclk);
      end
      busy = 1'b0;
   endtask
endmodule
